/* File: include/rps_pkg.sv */
// Package: constants and states of the reset pin sequencer
`default_nettype none
package rps_pkg;
   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned RELEASE_SHORT    = 2;
   localparam int unsigned DRIVE_LOW_CYCLES = 512;
   localparam int unsigned RELEASE_LONG     = 10;
   localparam int unsigned CNT_W            = 10;
   localparam logic [CNT_W-1:0] CNT_ZERO    = 10'h000;
   localparam logic [CNT_W-1:0] CNT_SHORT   = 10'(RELEASE_SHORT - 1);
   localparam logic [CNT_W-1:0] CNT_LOW     = 10'(DRIVE_LOW_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_LONG    = 10'(RELEASE_LONG - 1);
   localparam int unsigned FREQ_W           = 8;
   localparam logic [FREQ_W-1:0] FREQ_RESET = 8'h00;

   typedef enum logic [2:0] {
      RPS_POWERUP  = 3'b000,
      RPS_PROBE    = 3'b001,
      RPS_DRIVE    = 3'b010,
      RPS_RELEASE  = 3'b011,
      RPS_RUN      = 3'b100
   } rps_state_t;
endpackage
`default_nettype wire

/* File: rtl/rps_sync2.sv */
// Two flip-flop synchroniser for a pin level
`default_nettype none
module rps_sync2 (
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic d_in,
   output var  logic q_out
);
   logic meta_r;
   logic meta_nxt;
   logic q_nxt;

   always_comb begin
      meta_nxt = d_in;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         meta_r <= 1'b1;
         q_out  <= 1'b1;
      end else begin
         meta_r <= meta_nxt;
         q_out  <= q_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/rps_top.sv */
// Reset pin sequencer: start-up reset pulse loop and clock mode choice
// Function
// RULE1: Mode pin low during reset selects direct clock
// RULE2: Direct mode ignores synthesizer frequency bits
// RULE3: Direct mode passes external clock unchanged
// RULE4: Drive reset low until clock valid
// RULE5: On lock, release line two cycles
// RULE6: High during release means power-on reset
// RULE7: Low means external reset, drive 512
// RULE8: Then release ten cycles, sample at end
// RULE9: High at sample starts program execution
// RULE10: Low at sample repeats drive loop
// RULE11: Direct mode accepts clock without lock wait
// RULE12: Outside drivers only open-drain, never high
// RULE13: Synchronise reset line before any decision
`default_nettype none
module rps_top
   import rps_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   input  wire logic              reset_line_in,
   input  wire logic              clock_mode_select_pin_in,
   input  wire logic              pll_lock_in,
   input  wire logic              synth_clk_in,
   input  wire logic              external_clock_input_in,
   input  wire logic [FREQ_W-1:0] synthesizer_control_register_in,
   output var  logic              reset_line_out,
   output var  logic              reset_line_oe_out,
   output var  logic              direct_clock_mode_out,
   output var  logic [FREQ_W-1:0] synth_freq_out,
   output var  logic              sysclk_sel_out,
   output var  logic              power_on_reset_out,
   output var  logic              external_reset_out,
   output var  logic              run_out
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic line_s;
   logic lock_s;
   logic unlock_s;
   logic mode_s;

   // RULE13: synchronise line level
   rps_sync2 u_sync_line (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .d_in     (reset_line_in),
      .q_out    (line_s)
   );
   // Lock path rests at unlocked: inverted through the synchroniser
   rps_sync2 u_sync_lock (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .d_in     (~pll_lock_in),
      .q_out    (unlock_s)
   );
   assign lock_s = ~unlock_s;
   rps_sync2 u_sync_mode (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .d_in     (clock_mode_select_pin_in),
      .q_out    (mode_s)
   );

   // ------------------------------------------------------------
   // Sequencer state
   // ------------------------------------------------------------
   rps_state_t       state_r;
   rps_state_t       state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             high_seen_r;
   logic             high_seen_nxt;
   logic             direct_r;
   logic             direct_nxt;
   logic [FREQ_W-1:0] freq_r;
   logic [FREQ_W-1:0] freq_nxt;
   logic             oe_r;
   logic             oe_nxt;
   logic             por_r;
   logic             por_nxt;
   logic             ext_r;
   logic             ext_nxt;
   logic             run_r;
   logic             run_nxt;
   logic             clk_valid;

   // RULE11: direct mode clock valid at once
   assign clk_valid = direct_r | lock_s;

   always_comb begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      high_seen_nxt = high_seen_r;
      direct_nxt    = direct_r;
      freq_nxt      = freq_r;
      oe_nxt        = oe_r;
      por_nxt       = por_r;
      ext_nxt       = ext_r;
      run_nxt       = run_r;
      // RULE2: frequency bits frozen in direct mode
      if (!direct_r) begin
         freq_nxt = synthesizer_control_register_in;
      end
      case (state_r)
         RPS_POWERUP: begin
            // RULE1: mode latched while in reset
            direct_nxt = ~mode_s;
            // RULE4: hold line low until clock valid
            oe_nxt = 1'b1;
            if (clk_valid) begin
               // RULE5: release for two cycles
               state_nxt     = RPS_PROBE;
               cnt_nxt       = CNT_ZERO;
               high_seen_nxt = 1'b0;
               oe_nxt        = 1'b0;
            end
         end
         RPS_PROBE: begin
            cnt_nxt = cnt_r + 10'h001;
            if (cnt_r == CNT_SHORT) begin
               // RULE5: window over, drive while samples arrive
               cnt_nxt   = CNT_ZERO;
               oe_nxt    = 1'b1;
               state_nxt = RPS_DRIVE;
            end
         end
         RPS_DRIVE: begin
            cnt_nxt = cnt_r + 10'h001;
            // Window levels trail by the synchroniser depth
            if (!ext_r) begin
               high_seen_nxt = high_seen_r | line_s;
               if (cnt_r == CNT_SHORT) begin
                  if (high_seen_r | line_s) begin
                     // RULE6: power-on reset classified
                     cnt_nxt   = CNT_ZERO;
                     oe_nxt    = 1'b0;
                     por_nxt   = 1'b1;
                     run_nxt   = 1'b1;
                     state_nxt = RPS_RUN;
                  end else begin
                     // RULE7: external reset, keep driving low
                     ext_nxt = 1'b1;
                  end
               end
            end
            if (cnt_r == CNT_LOW) begin
               // RULE8: release ten cycles
               cnt_nxt   = CNT_ZERO;
               oe_nxt    = 1'b0;
               state_nxt = RPS_RELEASE;
            end
         end
         RPS_RELEASE: begin
            cnt_nxt = cnt_r + 10'h001;
            if (cnt_r == CNT_LONG) begin
               cnt_nxt = CNT_ZERO;
               if (line_s) begin
                  // RULE9: leave reset and run
                  run_nxt   = 1'b1;
                  state_nxt = RPS_RUN;
               end else begin
                  // RULE10: repeat drive loop
                  oe_nxt    = 1'b1;
                  state_nxt = RPS_DRIVE;
               end
            end
         end
         RPS_RUN: begin
            oe_nxt = 1'b0;
         end
         default: begin
            state_nxt = RPS_POWERUP;
            oe_nxt    = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_r     <= RPS_POWERUP;
         cnt_r       <= CNT_ZERO;
         high_seen_r <= 1'b0;
         direct_r    <= 1'b0;
         freq_r      <= FREQ_RESET;
         oe_r        <= 1'b1;
         por_r       <= 1'b0;
         ext_r       <= 1'b0;
         run_r       <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         high_seen_r <= high_seen_nxt;
         direct_r    <= direct_nxt;
         freq_r      <= freq_nxt;
         oe_r        <= oe_nxt;
         por_r       <= por_nxt;
         ext_r       <= ext_nxt;
         run_r       <= run_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // RULE12: line only ever driven low
   assign reset_line_out        = 1'b0;
   assign reset_line_oe_out     = oe_r;
   assign direct_clock_mode_out = direct_r;
   assign synth_freq_out        = freq_r;
   // RULE3: select raw external clock in direct mode
   assign sysclk_sel_out        = direct_r;
   assign power_on_reset_out    = por_r;
   assign external_reset_out    = ext_r;
   assign run_out               = run_r;

   logic unused_clk;
   assign unused_clk = synth_clk_in ^ external_clock_input_in;
endmodule
`default_nettype wire

/* File: verification/rps_reset_drv.sv */
// Open-drain outside reset driver with pull-up
`default_nettype none
module rps_reset_drv (
   input  wire logic dut_oe_in,
   input  wire logic hold_low_in,
   output var  logic line_out
);
   always_comb line_out = !(dut_oe_in || hold_low_in);
endmodule
`default_nettype wire

/* File: verification/rps_chk.sv */
// Port checker for the reset pin sequencer
`default_nettype none
module rps_chk
   import rps_pkg::*;
(
   input wire logic              clk_in,
   input wire logic              reset_in,
   input wire logic              reset_line_out,
   input wire logic              reset_line_oe_out,
   input wire logic              direct_clock_mode_out,
   input wire logic [FREQ_W-1:0] synth_freq_out,
   input wire logic              sysclk_sel_out,
   input wire logic              power_on_reset_out,
   input wire logic              external_reset_out,
   input wire logic              run_out
);
   logic [10:0] hi_r;
   logic [10:0] hi_nxt;
   always_comb hi_nxt = reset_line_oe_out ? hi_r + 11'h001 : 11'h000;
   always_ff @(posedge clk_in) hi_r <= reset_in ? 11'h000 : hi_nxt;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   low_only_a: assert property (!reset_line_out)
      else $error("line driven high");
   probe_win_a: assert property ($fell(reset_line_oe_out) && !external_reset_out && !power_on_reset_out
      |-> ##1 !reset_line_oe_out ##1 reset_line_oe_out[*2]
      ##1 (reset_line_oe_out && external_reset_out || run_out && power_on_reset_out && !reset_line_oe_out))
      else $error("probe window");
   drive_len_a: assert property ($fell(reset_line_oe_out) && external_reset_out |-> hi_r == 11'h200)
      else $error("drive length");
   release_len_a: assert property ($fell(reset_line_oe_out) && external_reset_out
      |-> (!reset_line_oe_out)[*5] ##1 (!reset_line_oe_out)[*5] ##1 (reset_line_oe_out || run_out))
      else $error("release length");
   run_free_a: assert property (run_out |=> run_out && !reset_line_oe_out)
      else $error("run lost");
   ext_drive_a: assert property ($rose(external_reset_out) |-> reset_line_oe_out && !run_out)
      else $error("ext not driving");
   por_run_a: assert property ($rose(power_on_reset_out) |-> run_out && !external_reset_out)
      else $error("por without run");
   freq_hold_a: assert property (direct_clock_mode_out |=> $stable(synth_freq_out))
      else $error("freq moved");
   sel_direct_a: assert property (direct_clock_mode_out |-> sysclk_sel_out)
      else $error("clock not direct");
   cover property ($rose(run_out) && power_on_reset_out);
   cover property ($rose(run_out) && external_reset_out);
   cover property ($rose(run_out) && direct_clock_mode_out);
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Testbench for the reset pin sequencer
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst, mode, lock, hold, line, oe, lo, dir, sel, por, ext, run;
   logic [7:0] synth, freq;
   int         failures = 0;
   int         total_checks = 0;
   rps_top u_dut (
      .clk_in(clk), .reset_in(rst), .reset_line_in(line),
      .clock_mode_select_pin_in(mode), .pll_lock_in(lock),
      .synth_clk_in(1'b0), .external_clock_input_in(1'b0),
      .synthesizer_control_register_in(synth), .reset_line_out(lo),
      .reset_line_oe_out(oe), .direct_clock_mode_out(dir), .synth_freq_out(freq),
      .sysclk_sel_out(sel), .power_on_reset_out(por), .external_reset_out(ext), .run_out(run)
   );
   rps_reset_drv u_drv (.dut_oe_in(oe), .hold_low_in(hold), .line_out(line));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wait_on(input logic s, input logic v);
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk);
         #1;
         if ((s ? run : oe) === v) return;
      end
      failures++;
      test_done;
   endtask
   task automatic start(input logic m, input logic h);
      @(posedge clk);
      rst <= 1'b1;
      mode <= m;
      hold <= h;
      lock <= 1'b0;
      synth <= 8'h00;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (20) @(posedge clk);
      lock <= m;
      #1;
      if (m) chk(oe, 1'b1, "line not held");
   endtask
   task automatic t_por;
      start(1'b1, 1'b0);
      wait_on(1'b1, 1'b1);
      chk(por, 1'b1, "por flag");
      chk(ext, 1'b0, "ext flag");
      chk(lo, 1'b0, "line high");
      chk(dir, 1'b0, "pll mode");
      chk(sel, 1'b0, "clock sel");
      @(posedge clk);
      synth <= 8'h5a;
      repeat (2) @(posedge clk);
      #1;
      chk(freq, 8'h5a, "freq");
      $display("por test done");
   endtask
   task automatic t_ext;
      start(1'b1, 1'b1);
      wait_on(1'b0, 1'b0);
      wait_on(1'b0, 1'b1);
      repeat (2) @(posedge clk);
      #1;
      chk(oe, 1'b1, "line not driven");
      chk(ext, 1'b1, "ext flag");
      wait_on(1'b0, 1'b0);
      wait_on(1'b0, 1'b1);
      chk(run, 1'b0, "early run");
      @(posedge clk);
      hold <= 1'b0;
      wait_on(1'b1, 1'b1);
      chk(por, 1'b0, "por flag");
      $display("ext test done");
   endtask
   task automatic t_dir;
      start(1'b0, 1'b0);
      wait_on(1'b1, 1'b1);
      chk(dir, 1'b1, "direct");
      chk(sel, 1'b1, "clock sel");
      @(posedge clk);
      synth <= 8'ha5;
      repeat (3) @(posedge clk);
      #1;
      chk(freq, 8'h00, "freq moved");
      $display("direct test done");
   endtask
   initial begin
      {rst, mode, lock, hold, synth} = {1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
      t_por;
      t_ext;
      t_dir;
      test_done;
   end
endmodule
bind rps_top rps_chk u_chk (
   .clk_in(clk_in), .reset_in(reset_in), .reset_line_out(reset_line_out),
   .reset_line_oe_out(reset_line_oe_out), .direct_clock_mode_out(direct_clock_mode_out),
   .synth_freq_out(synth_freq_out), .sysclk_sel_out(sysclk_sel_out),
   .power_on_reset_out(power_on_reset_out), .external_reset_out(external_reset_out), .run_out(run_out)
);
`default_nettype wire
